//--- pkg/rmm_pkg.sv
// constants for the receive-module monitor register bank
`default_nettype none

package rmm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus geometry: one printed offset is one register index, one 32-bit word
   localparam int          BUS_ADDR_W   = 9;
   localparam int          BUS_DATA_W   = 32;
   localparam int          IDX_W        = 7;
   localparam int          BYTE_W       = 8;
   localparam int          MON_W        = 16;
   localparam int          NUM_PAIRS    = 10;
   localparam logic [1:0]  WORD_ALIGNED = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // register indices (byte address is four times the index)
   localparam logic [6:0]  IDX_ALARM      = 7'h1b;
   localparam logic [6:0]  IDX_TEMP_INT   = 7'h1c;
   localparam logic [6:0]  IDX_TEMP_FRAC  = 7'h1d;
   localparam logic [6:0]  IDX_RSVD_A_LO  = 7'h1e;
   localparam logic [6:0]  IDX_RSVD_A_HI  = 7'h1f;
   localparam logic [6:0]  IDX_V33_HI     = 7'h20;
   localparam logic [6:0]  IDX_V25_HI     = 7'h22;
   localparam logic [6:0]  IDX_RSVD_B_LO  = 7'h24;
   localparam logic [6:0]  IDX_RSVD_B_HI  = 7'h3f;
   localparam logic [6:0]  IDX_PWR_CH11   = 7'h40;
   localparam logic [6:0]  IDX_PWR_CH10   = 7'h42;
   localparam logic [6:0]  IDX_PWR_CH9    = 7'h44;
   localparam logic [6:0]  IDX_PWR_CH8    = 7'h46;
   localparam logic [6:0]  IDX_PWR_CH7    = 7'h48;
   localparam logic [6:0]  IDX_PWR_CH6    = 7'h4a;
   localparam logic [6:0]  IDX_PWR_CH5    = 7'h4c;
   localparam logic [6:0]  IDX_IRQ_STATUS = 7'h50;
   localparam logic [6:0]  IDX_IRQ_MASK   = 7'h51;

   // upper-byte index of each two-byte monitor; slot 0 is the temperature
   localparam logic [9:0][6:0] MON_HI_IDX = {IDX_PWR_CH5, IDX_PWR_CH6, IDX_PWR_CH7,
                                             IDX_PWR_CH8, IDX_PWR_CH9, IDX_PWR_CH10,
                                             IDX_PWR_CH11, IDX_V25_HI, IDX_V33_HI,
                                             IDX_TEMP_INT};

   ////////////////////////////////////////////////////////////////////////////
   // alarm byte layout, shared by the irq status and mask registers
   localparam int          BIT_HI_CH1   = 7;
   localparam int          BIT_LO_CH1   = 6;
   localparam int          BIT_HI_CH0   = 3;
   localparam int          BIT_LO_CH0   = 2;
   localparam logic [7:0]  ALARM_BITS   = 8'hcc;
   localparam logic [7:0]  ALARM_RESET  = 8'h00;
   localparam logic [15:0] SHADOW_RESET = 16'h0000;
   localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

endpackage : rmm_pkg

`default_nettype wire

//--- src/rmm_regs.sv
// receive-module monitor register bank with an avalon-mm slave port
//
// Function
// - alarm byte 27 bit 7 is channel 1 high power, bit 6 channel 1 low.
// - alarm byte 27 bit 3 is channel 0 high power, bit 2 channel 0 low.
// - alarm byte bits 5-4 and 1-0 are reserved, read-only, read zero.
// - a flag reads one once its condition occurred and stays set until read.
// - reading the alarm byte returns latches, then clears flags whose condition left.
// - byte 28 returns temperature integer part, signed two's complement degrees.
// - byte 29 returns temperature fraction in 1/256 degree steps.
// - bytes 32-33 return 3.3 V supply in 100 uV steps, 32 is upper.
// - bytes 34-35 return 2.5 V supply in 100 uV steps, 34 is upper.
// - reserved bytes 30-31 and 36-63 always read zero.
// - each channel power monitor is a 16-bit count of 0.1 uW steps.
// - power pairs start at 64 with channel 11, descending to channel 5 at 76.
// - in each power pair the lower-addressed byte holds the upper eight bits.
`timescale 1ns/1ps
`default_nettype none

module rmm_regs
   import rmm_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          reset,
   // avalon-mm slave
   input  wire logic [rmm_pkg::BUS_ADDR_W-1:0] address,
   input  wire logic                          read,
   input  wire logic                          write,
   input  wire logic [rmm_pkg::BUS_DATA_W-1:0] writedata,
   input  wire logic [3:0]                    byteenable,
   output var  logic [rmm_pkg::BUS_DATA_W-1:0] readdata,
   output var  logic                          waitrequest,
   // live power conditions, level
   input  wire logic                          alarm_high_ch1,
   input  wire logic                          alarm_low_ch1,
   input  wire logic                          alarm_high_ch0,
   input  wire logic                          alarm_low_ch0,
   // live measurements
   input  wire logic [7:0]                    temp_integer,
   input  wire logic [7:0]                    temp_fraction,
   input  wire logic [15:0]                   supply_3v3,
   input  wire logic [15:0]                   supply_2v5,
   input  wire logic [15:0]                   rx_power_ch11,
   input  wire logic [15:0]                   rx_power_ch10,
   input  wire logic [15:0]                   rx_power_ch9,
   input  wire logic [15:0]                   rx_power_ch8,
   input  wire logic [15:0]                   rx_power_ch7,
   input  wire logic [15:0]                   rx_power_ch6,
   input  wire logic [15:0]                   rx_power_ch5,
   // interrupt, level
   output var  logic                          irq
);
   import rmm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [IDX_W-1:0]       idx;
   logic                   idx_ok;
   logic                   req;
   logic                   start;
   logic                   accept;
   logic                   rd_start;
   logic                   rd_accept;
   logic                   wr_accept;
   logic                   hit_alarm;
   logic                   hit_stat;
   logic                   hit_mask;
   logic [7:0]             alarm_flags;
   logic [7:0]             alarm_cond;
   logic [7:0]             alarm_reported;
   logic [7:0]             alarm_clear;
   logic [7:0]             alarm_events;
   logic [7:0]             next_alarm_flags;
   logic [7:0]             irq_status;
   logic [7:0]             irq_mask;
   logic [7:0]             stat_w1c;
   logic [7:0]             next_irq_status;
   logic [7:0]             next_irq_mask;
   logic [7:0]             ctrl_byte;
   logic [7:0]             mon_byte;
   logic [BUS_DATA_W-1:0]  next_readdata;
   logic [NUM_PAIRS-1:0][MON_W-1:0] mon_val;
   logic [MON_W-1:0]                shadow [NUM_PAIRS];
   logic [NUM_PAIRS:0][7:0]         pair_or;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode: a request is seen with waitrequest high and answered the next
   // cycle; this costs one wait state but lets readdata come from a flop
   assign idx       = address[BUS_ADDR_W-1:2];
   assign idx_ok    = (address[1:0] == WORD_ALIGNED);
   assign req       = read | write;
   assign start     = req & waitrequest;
   assign accept    = req & ~waitrequest;
   assign rd_start  = read & waitrequest;
   assign rd_accept = read & ~waitrequest;
   assign wr_accept = write & ~waitrequest & byteenable[0];
   assign hit_alarm = idx_ok & (idx == IDX_ALARM);
   assign hit_stat  = idx_ok & (idx == IDX_IRQ_STATUS);
   assign hit_mask  = idx_ok & (idx == IDX_IRQ_MASK);

   // handshake flop
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         waitrequest <= 1'b1;
      else
         waitrequest <= ~start;
   end

   ////////////////////////////////////////////////////////////////////////////
   // alarm latches: live conditions in the byte layout, reserved bits forced 0
   assign alarm_cond = {alarm_high_ch1, alarm_low_ch1, 2'b00,
                        alarm_high_ch0, alarm_low_ch0, 2'b00} & ALARM_BITS;

   // only bits shown to software by this read are cleared, so a condition that
   // rises between capture and accept is not lost; a live condition always wins
   assign alarm_clear      = (rd_accept & hit_alarm) ? alarm_reported : 8'h00;
   assign next_alarm_flags = alarm_cond | (alarm_flags & ~alarm_clear);
   assign alarm_events     = alarm_cond & ~alarm_flags;

   // latch flops; writes never reach them
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         alarm_flags <= ALARM_RESET;
      else
         alarm_flags <= next_alarm_flags & ALARM_BITS;
   end

   // snapshot of what the pending alarm read returns
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         alarm_reported <= ALARM_RESET;
      else if (rd_start & hit_alarm)
         alarm_reported <= alarm_flags;
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status (write one to clear, new event wins) and mask
   assign stat_w1c        = (wr_accept & hit_stat) ? writedata[7:0] : 8'h00;
   assign next_irq_status = ((irq_status & ~stat_w1c) | alarm_events) & ALARM_BITS;
   assign next_irq_mask   = (wr_accept & hit_mask) ? (writedata[7:0] & ALARM_BITS)
                                                   : irq_mask;

   // irq flops; irq trails the status by one cycle
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         irq_status <= ALARM_RESET;
         irq_mask   <= ALARM_RESET;
         irq        <= 1'b0;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq_mask   <= next_irq_mask;
         irq        <= |(irq_status & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-byte monitors, slot order follows MON_HI_IDX
   assign mon_val[0] = {temp_integer, temp_fraction};
   assign mon_val[1] = supply_3v3;
   assign mon_val[2] = supply_2v5;
   assign mon_val[3] = rx_power_ch11;
   assign mon_val[4] = rx_power_ch10;
   assign mon_val[5] = rx_power_ch9;
   assign mon_val[6] = rx_power_ch8;
   assign mon_val[7] = rx_power_ch7;
   assign mon_val[8] = rx_power_ch6;
   assign mon_val[9] = rx_power_ch5;
   assign pair_or[0] = 8'h00;

   // per slot: upper byte live, lower byte from the copy taken with the upper
   for (genvar p = 0; p < NUM_PAIRS; p++)
   begin : g_pair
      logic       hit_hi;
      logic       hit_lo;
      logic [7:0] slot_byte;

      assign hit_hi    = idx_ok & (idx == MON_HI_IDX[p]);
      assign hit_lo    = idx_ok & (idx == (MON_HI_IDX[p] | 7'h01));
      assign slot_byte = hit_hi ? mon_val[p][15:8] :
                         hit_lo ? shadow[p][7:0]   : 8'h00;
      assign pair_or[p+1] = pair_or[p] | slot_byte;

      // whole value is frozen when the upper byte is read
      always_ff @(posedge clk or posedge reset)
      begin
         if (reset)
            shadow[p] <= SHADOW_RESET;
         else if (rd_start & hit_hi)
            shadow[p] <= mon_val[p];
      end
   end

   assign mon_byte = pair_or[NUM_PAIRS];

   ////////////////////////////////////////////////////////////////////////////
   // read mux: anything not decoded, reserved gaps included, returns zero
   assign ctrl_byte = hit_alarm ? alarm_flags :
                      hit_stat  ? irq_status  :
                      hit_mask  ? irq_mask    : 8'h00;
   assign next_readdata = {24'h00_0000, ctrl_byte | mon_byte};

   // read data flop, loaded when the request is first seen
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         readdata <= RDATA_ZERO;
      else if (rd_start)
         readdata <= next_readdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [7:0] ast_lo_copy;
   logic       ast_rd_ans;

   assign ast_rd_ans = rd_accept & idx_ok;

   // reference copy of the 3.3 V lower byte at its upper-byte read
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         ast_lo_copy <= 8'h00;
      else if (rd_start & idx_ok & (idx == IDX_V33_HI))
         ast_lo_copy <= supply_3v3[7:0];
   end

   AST_ALARM_HI1_SETS: assert property (@(posedge clk) disable iff (reset)
      alarm_high_ch1 |=> alarm_flags[BIT_HI_CH1])
      else $error("channel 1 high alarm not latched");

   AST_ALARM_LO0_SETS: assert property (@(posedge clk) disable iff (reset)
      alarm_low_ch0 |=> alarm_flags[BIT_LO_CH0])
      else $error("channel 0 low alarm not latched");

   AST_ALARM_RSVD_ZERO: assert property (@(posedge clk) disable iff (reset)
      (ast_rd_ans & (idx == IDX_ALARM)) |-> (readdata[5:4] == 2'b00 &&
                                             readdata[1:0] == 2'b00 &&
                                             readdata[31:8] == 24'h00_0000))
      else $error("reserved alarm bits read nonzero");

   AST_ALARM_HOLDS: assert property (@(posedge clk) disable iff (reset)
      (alarm_flags[BIT_HI_CH0] && !(rd_accept && hit_alarm))
         |=> alarm_flags[BIT_HI_CH0])
      else $error("latched alarm dropped without a read");

   AST_ALARM_CLEARS: assert property (@(posedge clk) disable iff (reset)
      (rd_accept && hit_alarm && readdata[BIT_LO_CH1] && !alarm_low_ch1)
         |=> !alarm_flags[BIT_LO_CH1])
      else $error("alarm read did not clear a gone condition");

   AST_ALARM_READ_VALUE: assert property (@(posedge clk) disable iff (reset)
      (rd_start && hit_alarm) |=> (readdata[7:0] == $past(alarm_flags)))
      else $error("alarm read returned wrong latch value");

   AST_TEMP_INT: assert property (@(posedge clk) disable iff (reset)
      (ast_rd_ans & (idx == IDX_TEMP_INT)) |-> (readdata[7:0] == $past(temp_integer)))
      else $error("temperature integer byte wrong");

   AST_V33_UPPER: assert property (@(posedge clk) disable iff (reset)
      (ast_rd_ans & (idx == IDX_V33_HI)) |-> (readdata[7:0] == $past(supply_3v3[15:8])))
      else $error("3.3 V upper byte wrong");

   AST_V33_LOWER_PAIRED: assert property (@(posedge clk) disable iff (reset)
      (ast_rd_ans & (idx == (IDX_V33_HI | 7'h01))) |-> (readdata[7:0] == ast_lo_copy))
      else $error("3.3 V lower byte not from the same capture");

   AST_V25_UPPER: assert property (@(posedge clk) disable iff (reset)
      (ast_rd_ans & (idx == IDX_V25_HI)) |-> (readdata[7:0] == $past(supply_2v5[15:8])))
      else $error("2.5 V upper byte wrong");

   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (reset)
      (ast_rd_ans & ((idx >= IDX_RSVD_A_LO && idx <= IDX_RSVD_A_HI) ||
                     (idx >= IDX_RSVD_B_LO && idx <= IDX_RSVD_B_HI)))
         |-> (readdata == RDATA_ZERO))
      else $error("reserved byte read nonzero");

   AST_PWR_CH11_UPPER: assert property (@(posedge clk) disable iff (reset)
      (ast_rd_ans & (idx == IDX_PWR_CH11)) |-> (readdata[7:0] == $past(rx_power_ch11[15:8])))
      else $error("channel 11 power upper byte wrong");

   AST_PWR_CH5_UPPER: assert property (@(posedge clk) disable iff (reset)
      (ast_rd_ans & (idx == IDX_PWR_CH5)) |-> (readdata[7:0] == $past(rx_power_ch5[15:8])))
      else $error("channel 5 power upper byte wrong");

   AST_WRITE_IGNORED: assert property (@(posedge clk) disable iff (reset)
      (write && !waitrequest && hit_alarm && alarm_cond == 8'h00) |=> $stable(alarm_flags))
      else $error("write disturbed the alarm latches");

   AST_ANSWER_ONE_WAIT: assert property (@(posedge clk) disable iff (reset)
      (req && waitrequest) |=> (!waitrequest ##1 waitrequest))
      else $error("bus answer not after exactly one wait state");

   AST_IRQ_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
      (|(irq_status & irq_mask)) |=> irq)
      else $error("irq not raised for an unmasked status bit");

   COV_ALARM_READ_CLEAR: cover property (@(posedge clk) disable iff (reset)
      rd_accept && hit_alarm && (readdata[7:0] != 8'h00) ##1 (alarm_flags == 8'h00));

   COV_PAIR_READ: cover property (@(posedge clk) disable iff (reset)
      (ast_rd_ans && idx == IDX_PWR_CH11) ##[1:20]
      (ast_rd_ans && idx == (IDX_PWR_CH11 | 7'h01)));

   COV_IRQ: cover property (@(posedge clk) disable iff (reset) $rose(irq));

   COV_BACK_TO_BACK: cover property (@(posedge clk) disable iff (reset)
      accept ##1 (req && waitrequest));

endmodule : rmm_regs

`default_nettype wire

//--- dv/rmm_tb.sv
// self-checking bench for the receive-module monitor register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import rmm_pkg::*;

   logic        clk;
   logic        reset;
   logic        read;
   logic        write;
   logic [8:0]  address;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic [31:0] rd;
   logic [3:0]  byteenable;
   logic        waitrequest;
   logic        irq;
   logic        a_h1;
   logic        a_l1;
   logic        a_h0;
   logic        a_l0;
   logic [7:0]  t_int;
   logic [7:0]  t_frac;
   logic [15:0] v33;
   logic [15:0] v25;
   logic [15:0] pw [7];
   int          failures;
   int          compares;

   rmm_regs dut (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .alarm_high_ch1(a_h1), .alarm_low_ch1(a_l1),
      .alarm_high_ch0(a_h0), .alarm_low_ch0(a_l0), .temp_integer(t_int),
      .temp_fraction(t_frac), .supply_3v3(v33), .supply_2v5(v25),
      .rx_power_ch11(pw[0]), .rx_power_ch10(pw[1]), .rx_power_ch9(pw[2]),
      .rx_power_ch8(pw[3]), .rx_power_ch7(pw[4]), .rx_power_ch6(pw[5]),
      .rx_power_ch5(pw[6]), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   // clock at 50 MHz
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared checking and bus tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one avalon transfer; the request stands until waitrequest is sampled low,
   // and only the watchdog ends a wait that never gets an answer
   task automatic bus(input logic we, input logic [6:0] idx, input logic [7:0] wd,
                      input logic [1:0] lo);
      int n;
      @(posedge clk);
      read      <= ~we;
      write     <= we;
      address   <= {idx, lo};
      writedata <= {24'h0, wd};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0);
      chk("answer edges", 32'h2, 32'(n));
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic rreg(input string name, input logic [6:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00, 2'h0);
      chk(name, {24'h0, exp}, rd);
   endtask

   task automatic wreg(input logic [6:0] idx, input logic [7:0] wd);
      bus(1'b1, idx, wd, 2'h0);
   endtask

   // wait long enough for the registered irq to follow its cause
   task automatic irq_is(input logic exp);
      repeat (3) @(posedge clk);
      chk("irq", {31'h0, exp}, {31'h0, irq});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      chk("irq after reset", 32'h0, {31'h0, irq});
      chk("waitrequest after reset", 32'h1, {31'h0, waitrequest});
      chk("readdata after reset", 32'h0, readdata);
      rreg("alarm after reset", IDX_ALARM, 8'h00);
      rreg("mask after reset", IDX_IRQ_MASK, 8'h00);
      $display("test reset done");
   endtask

   // short pulses must stay latched; live conditions survive a read
   task automatic t_alarm();
      @(posedge clk);
      a_h1 <= 1'b1;
      a_l0 <= 1'b1;
      @(posedge clk);
      a_h1 <= 1'b0;
      a_l0 <= 1'b0;
      repeat (2) @(posedge clk);
      rreg("alarm hi1 lo0", IDX_ALARM, 8'h84);
      rreg("alarm cleared", IDX_ALARM, 8'h00);
      a_l1 <= 1'b1;
      a_h0 <= 1'b1;
      rreg("alarm lo1 hi0", IDX_ALARM, 8'h48);
      rreg("alarm live kept", IDX_ALARM, 8'h48);
      a_l1 <= 1'b0;
      a_h0 <= 1'b0;
      rreg("alarm latched", IDX_ALARM, 8'h48);
      rreg("alarm gone", IDX_ALARM, 8'h00);
      $display("test alarm done");
   endtask

   task automatic t_irq();
      wreg(IDX_IRQ_STATUS, 8'hff);
      rreg("status cleared", IDX_IRQ_STATUS, 8'h00);
      wreg(IDX_IRQ_MASK, 8'h08);
      rreg("mask readback", IDX_IRQ_MASK, 8'h08);
      // a write with the low byte lane off must leave the mask alone
      byteenable <= 4'he;
      wreg(IDX_IRQ_MASK, 8'hcc);
      byteenable <= 4'hf;
      rreg("mask lane off", IDX_IRQ_MASK, 8'h08);
      a_h0 <= 1'b1;
      irq_is(1'b1);
      rreg("status set", IDX_IRQ_STATUS, 8'h08);
      a_h0 <= 1'b0;
      wreg(IDX_IRQ_MASK, 8'h00);
      irq_is(1'b0);
      wreg(IDX_IRQ_MASK, 8'h08);
      irq_is(1'b1);
      wreg(IDX_IRQ_STATUS, 8'h08);
      irq_is(1'b0);
      rreg("status after clear", IDX_IRQ_STATUS, 8'h00);
      rreg("alarm hi0", IDX_ALARM, 8'h08);
      rreg("alarm empty", IDX_ALARM, 8'h00);
      $display("test irq done");
   endtask

   // every monitor pair, upper byte first
   task automatic t_mon();
      logic [15:0] v;
      rreg("temp int", IDX_TEMP_INT, 8'he7);
      rreg("temp frac", IDX_TEMP_FRAC, 8'h80);
      rreg("v33 hi", IDX_V33_HI, 8'h82);
      v33 <= 16'h7f01;
      rreg("v33 lo held", IDX_V33_HI + 7'h1, 8'h35);
      rreg("v33 hi new", IDX_V33_HI, 8'h7f);
      rreg("v33 lo new", IDX_V33_HI + 7'h1, 8'h01);
      rreg("v25 hi", IDX_V25_HI, 8'h61);
      rreg("v25 lo", IDX_V25_HI + 7'h1, 8'ha8);
      for (int k = 0; k < 7; k++)
      begin
         v = 16'hc0d0 + 16'(k * 16'h1111);
         rreg("power hi", 7'h40 + 7'(2 * k), v[15:8]);
         rreg("power lo", 7'h41 + 7'(2 * k), v[7:0]);
      end
      $display("test monitors done");
   endtask

   // reserved places read zero, writes change nothing
   task automatic t_rsvd();
      logic [6:0] rs [6] = '{7'h1e, 7'h1f, 7'h24, 7'h30, 7'h3f, 7'h4e};
      foreach (rs[i])
         rreg("reserved", rs[i], 8'h00);
      bus(1'b0, IDX_TEMP_INT, 8'h00, 2'h2);
      chk("misaligned", 32'h0, rd);
      a_h1 <= 1'b1;
      @(posedge clk);
      a_h1 <= 1'b0;
      foreach (rs[i])
         wreg(rs[i], 8'hff);
      wreg(IDX_ALARM, 8'hff);
      wreg(IDX_TEMP_INT, 8'h00);
      wreg(IDX_PWR_CH11, 8'h00);
      rreg("alarm after write", IDX_ALARM, 8'h80);
      rreg("reserved after write", 7'h30, 8'h00);
      rreg("temp after write", IDX_TEMP_INT, 8'he7);
      rreg("power after write", IDX_PWR_CH11, 8'hc0);
      $display("test reserved done");
   endtask

   // reset in mid-run drops latches, status and mask even with events pending
   task automatic t_reset_mid();
      a_l1 <= 1'b1;
      @(posedge clk);
      a_l1  <= 1'b0;
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk("waitrequest after mid reset", 32'h1, {31'h0, waitrequest});
      chk("irq after mid reset", 32'h0, {31'h0, irq});
      rreg("alarm after mid reset", IDX_ALARM, 8'h00);
      rreg("mask after mid reset", IDX_IRQ_MASK, 8'h00);
      rreg("status after mid reset", IDX_IRQ_STATUS, 8'h00);
      $display("test mid reset done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // verdict, reached from the main sequence or the watchdog
   task automatic results();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      #200000;
      failures++;
      results();
   end

   initial
   begin
      failures   = 0;
      compares   = 0;
      reset      = 1'b1;
      read       = 1'b0;
      write      = 1'b0;
      address    = 9'h000;
      writedata  = 32'h0;
      byteenable = 4'hf;
      a_h1       = 1'b0;
      a_l1       = 1'b0;
      a_h0       = 1'b0;
      a_l0       = 1'b0;
      t_int      = 8'he7;
      t_frac     = 8'h80;
      v33        = 16'h8235;
      v25        = 16'h61a8;
      for (int k = 0; k < 7; k++)
         pw[k] = 16'hc0d0 + 16'(k * 16'h1111);
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_alarm();
      t_irq();
      t_mon();
      t_rsvd();
      t_reset_mid();
      results();
   end

endmodule // testbench

`default_nettype wire
